// >>> verilog/spg_pkg.sv
// Shared constants and types for the spread grayscale PWM engine
package spg_pkg;
  // Counter and channel geometry
  localparam int SPG_COUNT_W = 16;
  localparam int SPG_NUM_CH = 12;
  localparam int SPG_SEG_W = 7;
  localparam int SPG_POS_W = 9;
  localparam int SPG_SEG_COUNT = 128;
  localparam int SPG_SEG_SPAN = 512;

  // Timing of the internal reference clock
  localparam int SPG_CLK_PERIOD_NS = 20;
  localparam int SPG_INT_PERIOD_NS = 100;
  localparam int SPG_INT_DIV = (SPG_INT_PERIOD_NS + SPG_CLK_PERIOD_NS - 1) / SPG_CLK_PERIOD_NS;
  localparam int SPG_INT_HALF = SPG_INT_DIV / 2;

  // Register bus geometry
  localparam int SPG_ADDR_W = 8;
  localparam int SPG_DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] SPG_CTRL_OFS = 8'h00;
  localparam logic [7:0] SPG_STATUS_OFS = 8'h04;
  localparam logic [7:0] SPG_VALUE_BASE = 8'h10;
  localparam logic [7:0] SPG_VALUE_STEP = 8'h04;

  // Control field positions
  localparam int SPG_CTRL_BLANK_BIT = 0;
  localparam int SPG_CTRL_EXT_BIT = 1;
  localparam int SPG_CTRL_EDGE_BIT = 2;

  // Reset values
  localparam logic [15:0] SPG_COUNT_RESET = 16'h0000;
  localparam logic [15:0] SPG_VALUE_RESET = 16'h0000;
  localparam logic [31:0] SPG_RDATA_IDLE = 32'h0000_0000;

  typedef logic [SPG_COUNT_W-1:0] spg_value_t;

  // Latched control bits
  typedef struct packed {
    logic count_edge_select;
    logic external_count_clock_select;
    logic blank;
  } spg_cfg_s;

  localparam spg_cfg_s SPG_CFG_RESET = '{count_edge_select: 1'b1,
                                         external_count_clock_select: 1'b0,
                                         blank: 1'b1};
endpackage

// >>> verilog/spg_channel.sv
// One output channel: spread pulse comparator and output flop
module spg_channel
  import spg_pkg::*;
#(
  parameter int COUNT_W = SPG_COUNT_W
)
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Shared counter and channel value
  input wire logic [COUNT_W-1:0] count_in,
  input wire logic [COUNT_W-1:0] value_in,
  input wire logic blank_in,
  // Sink drive
  output logic on_out
);
  localparam int SEG_W = SPG_SEG_W;
  localparam int POS_W = COUNT_W - SEG_W;

  logic [SEG_W-1:0] seg_index;
  logic [SEG_W-1:0] seg_rank;
  logic [POS_W-1:0] seg_pos;
  logic [POS_W:0] seg_len;
  logic nxt_on;

  generate
    if (COUNT_W != SPG_SEG_W + SPG_POS_W)
    begin : g_chk
      $error("spg_channel: counter width must be segment plus position width");
    end
  endgenerate

  assign seg_index = count_in[COUNT_W-1:POS_W];
  assign seg_pos = count_in[POS_W-1:0];

  // Bit-reversed segment index is its rank in the spread order
  always_comb
  begin
    for (int i = 0; i < SEG_W; i++)
    begin
      seg_rank[i] = seg_index[SEG_W-1-i];
    end
  end

  // Base length per segment plus one where the rank lies below the low bits
  always_comb
  begin
    seg_len = {1'b0, value_in[COUNT_W-1:SEG_W]};
    if (seg_rank < value_in[SEG_W-1:0])
    begin
      seg_len = seg_len + {{POS_W{1'b0}}, 1'b1};
    end
  end

  // Pulse sits at the start of the segment; zero length never turns on
  assign nxt_on = !blank_in && ({1'b0, seg_pos} < seg_len);

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      on_out <= 1'b0;
    end
    else
    begin
      on_out <= nxt_on;
    end
  end
endmodule

// >>> verilog/spg_pwm_top.sv
// Spread grayscale PWM engine with register port and twelve sink outputs
module spg_pwm_top
  import spg_pkg::*;
#(
  parameter int NUM_CH = SPG_NUM_CH,
  parameter int INT_DIV = SPG_INT_DIV
)
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Serial clock pin
  input wire logic serial_clock_in,
  // Register port
  input wire logic [SPG_ADDR_W-1:0] reg_addr_in,
  input wire logic [SPG_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [SPG_DATA_W-1:0] reg_rdata_out,
  // Sink outputs
  output logic [NUM_CH-1:0] led_sink_output_out
);
  localparam int DIV_W = $clog2(INT_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(INT_DIV / 2);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  // Divider values one step past each reference edge phase
  localparam logic [DIV_W-1:0] DIV_RISE_START = DIV_W'(1 % INT_DIV);
  localparam logic [DIV_W-1:0] DIV_FALL_START = DIV_W'((INT_DIV / 2 + 1) % INT_DIV);

  generate
    if (NUM_CH < 1 || NUM_CH > 48)
    begin : g_chk_ch
      $error("spg_pwm_top: channel count out of range");
    end
    if (INT_DIV < 2)
    begin : g_chk_div
      $error("spg_pwm_top: internal divider must be at least two");
    end
    if (SPG_SEG_COUNT * SPG_SEG_SPAN != (1 << SPG_COUNT_W))
    begin : g_chk_seg
      $error("spg_pwm_top: segments must tile the counter");
    end
  endgenerate

  spg_cfg_s cfg_ff;
  spg_value_t value_ff [NUM_CH];
  logic [SPG_COUNT_W-1:0] count_ff;
  logic [SPG_COUNT_W-1:0] nxt_count;
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic [2:0] sck_sync_ff;
  logic sck_level_ff;
  logic park_rise;
  logic [SPG_DATA_W-1:0] rdata_ff;
  logic [SPG_DATA_W-1:0] nxt_rdata;
  logic int_rise;
  logic int_fall;
  logic ext_rise;
  logic ext_fall;
  logic count_tick;
  logic ctrl_wr;

  // Serial clock pin synchroniser
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sck_sync_ff <= 3'h0;
    end
    else
    begin
      sck_sync_ff <= {sck_sync_ff[1:0], serial_clock_in};
    end
  end

  // Accepted pin level moves only once stages two and three agree
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sck_level_ff <= 1'b0;
    end
    else if (sck_sync_ff[1] == sck_sync_ff[2])
    begin
      sck_level_ff <= sck_sync_ff[2];
    end
  end

  // Edge is a change of the accepted level
  assign ext_rise = sck_sync_ff[1] && sck_sync_ff[2] && !sck_level_ff;
  assign ext_fall = !sck_sync_ff[1] && !sck_sync_ff[2] && sck_level_ff;

  // Edge choice that will hold once a pending control write lands
  assign park_rise = ctrl_wr ? reg_wdata_in[SPG_CTRL_EDGE_BIT] : cfg_ff.count_edge_select;

  // Internal reference divider: rise at zero, fall at half period
  always_comb
  begin
    nxt_div = div_ff + DIV_W'(1);
    if (div_ff == DIV_LAST)
    begin
      nxt_div = DIV_ZERO;
    end
    // Parked while blanked so count zero lasts a full period after unblank
    if (cfg_ff.blank)
    begin
      nxt_div = park_rise ? DIV_RISE_START : DIV_FALL_START;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      div_ff <= '0;
    end
    else
    begin
      div_ff <= nxt_div;
    end
  end

  assign int_rise = (div_ff == DIV_ZERO);
  assign int_fall = (div_ff == DIV_HALF);

  // Source and edge choice
  always_comb
  begin
    if (cfg_ff.external_count_clock_select)
    begin
      count_tick = cfg_ff.count_edge_select ? ext_rise : ext_fall;
    end
    else
    begin
      count_tick = cfg_ff.count_edge_select ? int_rise : int_fall;
    end
  end

  // Shared grayscale counter, wraps to repeat the display period
  always_comb
  begin
    nxt_count = count_ff;
    if (cfg_ff.blank)
    begin
      nxt_count = SPG_COUNT_RESET;
    end
    else if (count_tick)
    begin
      nxt_count = count_ff + SPG_COUNT_W'(1);
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      count_ff <= SPG_COUNT_RESET;
    end
    else
    begin
      count_ff <= nxt_count;
    end
  end

  // Control register; blank starts set
  assign ctrl_wr = reg_write_in && (reg_addr_in == SPG_CTRL_OFS);

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cfg_ff <= SPG_CFG_RESET;
    end
    else if (ctrl_wr)
    begin
      cfg_ff.blank <= reg_wdata_in[SPG_CTRL_BLANK_BIT];
      cfg_ff.external_count_clock_select <= reg_wdata_in[SPG_CTRL_EXT_BIT];
      cfg_ff.count_edge_select <= reg_wdata_in[SPG_CTRL_EDGE_BIT];
    end
  end

  // Per-channel grayscale values and channel engines
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      localparam logic [SPG_ADDR_W-1:0] CH_OFS =
        SPG_ADDR_W'(SPG_VALUE_BASE + ch * SPG_VALUE_STEP);

      always_ff @(posedge clock_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          value_ff[ch] <= SPG_VALUE_RESET;
        end
        else if (reg_write_in && (reg_addr_in == CH_OFS))
        begin
          value_ff[ch] <= reg_wdata_in[SPG_COUNT_W-1:0];
        end
      end

      spg_channel #(
        .COUNT_W(SPG_COUNT_W)
      ) u_channel (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .count_in(count_ff),
        .value_in(value_ff[ch]),
        .blank_in(cfg_ff.blank),
        .on_out(led_sink_output_out[ch])
      );
    end
  endgenerate

  // Read path: data one cycle after the strobe, zero elsewhere
  always_comb
  begin
    nxt_rdata = SPG_RDATA_IDLE;
    if (reg_read_in)
    begin
      if (reg_addr_in == SPG_CTRL_OFS)
      begin
        nxt_rdata[SPG_CTRL_BLANK_BIT] = cfg_ff.blank;
        nxt_rdata[SPG_CTRL_EXT_BIT] = cfg_ff.external_count_clock_select;
        nxt_rdata[SPG_CTRL_EDGE_BIT] = cfg_ff.count_edge_select;
      end
      else if (reg_addr_in == SPG_STATUS_OFS)
      begin
        nxt_rdata[SPG_COUNT_W-1:0] = count_ff;
      end
      else
      begin
        for (int i = 0; i < NUM_CH; i++)
        begin
          if (reg_addr_in == SPG_ADDR_W'(SPG_VALUE_BASE + i * SPG_VALUE_STEP))
          begin
            nxt_rdata[SPG_COUNT_W-1:0] = value_ff[i];
          end
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rdata_ff <= SPG_RDATA_IDLE;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out = rdata_ff;
endmodule

// >>> tb/spg_pwm_assertions.sv
// Port checker for the spread grayscale PWM engine
module spg_pwm_assertions
  import spg_pkg::*;
#(
  parameter int NUM_CH = SPG_NUM_CH,
  parameter int INT_DIV = SPG_INT_DIV
)
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Watched ports
  input wire logic serial_clock_in,
  input wire logic [SPG_ADDR_W-1:0] reg_addr_in,
  input wire logic [SPG_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [SPG_DATA_W-1:0] reg_rdata_out,
  input wire logic [NUM_CH-1:0] led_sink_output_out
);
  import spg_pkg::*;
  logic [2:0] cfg_ff;
  localparam logic [7:0] ZERO_CH_OFS = 8'(SPG_VALUE_BASE + 9 * SPG_VALUE_STEP);
  logic [15:0] val0_ff;
  logic [15:0] val9_ff;
  logic [3:0] still_ff;
  logic ser_ff;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);
  // Shadow of control and channel 0 value
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      cfg_ff <= 3'h5;
    else if (reg_write_in && reg_addr_in == SPG_CTRL_OFS)
      cfg_ff <= reg_wdata_in[2:0];
  end
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      val0_ff <= 16'h0000;
    else if (reg_write_in && reg_addr_in == SPG_VALUE_BASE)
      val0_ff <= reg_wdata_in[15:0];
  end
  // Shadow of channel 9 value
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      val9_ff <= 16'h0000;
    else if (reg_write_in && reg_addr_in == ZERO_CH_OFS)
      val9_ff <= reg_wdata_in[15:0];
  end
  // Cycles the serial pin has stayed still
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ser_ff <= 1'b0;
      still_ff <= 4'h0;
    end
    else
    begin
      ser_ff <= serial_clock_in;
      if (serial_clock_in != ser_ff)
        still_ff <= 4'h0;
      else if (still_ff != 4'hF)
        still_ff <= still_ff + 4'h1;
    end
  end
  sequence s_rd_st;
    reg_read_in && reg_addr_in == SPG_STATUS_OFS && !cfg_ff[0];
  endsequence
  sequence s_rd_quiet;
    s_rd_st ##0 (cfg_ff[1] && still_ff >= 4'h6);
  endsequence
  AST_BLANK_OFF: assert property (cfg_ff[0] && $past(cfg_ff[0]) |-> !led_sink_output_out)
    else $error("output on while blanked");
  AST_ZERO_OFF: assert property (val9_ff == 0 && $past(val9_ff) == 0 |-> !led_sink_output_out[9])
    else $error("zero value output on");
  AST_CTRL_READ: assert property (reg_read_in && reg_addr_in == SPG_CTRL_OFS |=> reg_rdata_out == {29'h0, $past(cfg_ff)})
    else $error("control readback wrong");
  AST_STATUS_BLANK: assert property (reg_read_in && reg_addr_in == SPG_STATUS_OFS && cfg_ff[0] && $past(cfg_ff[0]) |=> reg_rdata_out == '0)
    else $error("counter not zero while blanked");
  AST_VAL0_READ: assert property (reg_read_in && reg_addr_in == SPG_VALUE_BASE |=> reg_rdata_out == {16'h0, $past(val0_ff)})
    else $error("value readback wrong");
  AST_VALUE_UPPER: assert property (reg_read_in && reg_addr_in >= SPG_VALUE_BASE |=> reg_rdata_out[31:16] == 16'h0000)
    else $error("value wider than 16 bits");
  AST_STATUS_STEP: assert property (s_rd_st ##1 s_rd_st |=> (reg_rdata_out - $past(reg_rdata_out)) inside {32'h0, 32'h1, 32'hFFFF_0001})
    else $error("counter jumped");
  AST_EXT_HOLD: assert property (s_rd_quiet ##1 s_rd_quiet |=> reg_rdata_out == $past(reg_rdata_out))
    else $error("counter moved without serial edge");
endmodule

bind spg_pwm_top spg_pwm_assertions #(.NUM_CH(NUM_CH), .INT_DIV(INT_DIV)) u_chk (
  .clock_in(clock_in), .resetn_in(resetn_in), .serial_clock_in(serial_clock_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .led_sink_output_out(led_sink_output_out));

// >>> tb/spg_sink_model.sv
// LED sink bank model tallying on-cycles per output
module spg_sink_model
#(
  parameter int NUM_CH = 12
)
(
  // Clock and tally clear
  input wire logic clock_in,
  input wire logic clear_in,
  // Sink drive
  input wire logic [NUM_CH-1:0] led_sink_output_in,
  // Tallies
  output logic [15:0] on_cnt_out [NUM_CH]
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clock_in)
  begin
    for (int i = 0; i < NUM_CH; i++)
      if (clear_in)
        on_cnt_out[i] <= 16'h0000;
      else if (led_sink_output_in[i])
        on_cnt_out[i] <= on_cnt_out[i] + 16'h0001;
  end
endmodule

// >>> tb/spg_pwm_top_tb.sv
// Self-checking bench for the spread grayscale PWM engine
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("CHECK FAILED at %0t: got %0h want %0h", $time, a, b); end end
module spg_pwm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import spg_pkg::*;
  localparam int DIV = 2;
  logic clock_in = 1'b0;
  logic resetn_in, serial_clock_in, reg_write_in, reg_read_in, clr;
  logic [SPG_ADDR_W-1:0] addr;
  logic [SPG_DATA_W-1:0] wdata, rdata, q;
  logic [SPG_NUM_CH-1:0] led;
  logic [15:0] on_cnt [SPG_NUM_CH];
  int error_cnt = 0;
  int n_tests = 0;
  logic [15:0] vals [12] = '{16'hFFFF, 16'h0001, 16'h0002, 16'h0003, 16'h0041, 16'h0080,
    16'h0081, 16'h0100, 16'h0181, 16'h0000, 16'h007F, 16'h0040};
  int ticks [12] = '{0, 1, 1, 1, 3, 3, 4, 6, 10, 0, 3, 2};
  spg_pwm_top #(.NUM_CH(SPG_NUM_CH), .INT_DIV(DIV)) uut (.clock_in(clock_in),
    .resetn_in(resetn_in), .serial_clock_in(serial_clock_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(rdata), .led_sink_output_out(led));
  spg_sink_model #(.NUM_CH(SPG_NUM_CH)) u_sink (.clock_in(clock_in), .clear_in(clr),
    .led_sink_output_in(led), .on_cnt_out(on_cnt));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    addr <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge clock_in);
      serial_clock_in <= 1'b1;
      repeat (6) @(posedge clock_in);
      serial_clock_in <= 1'b0;
      repeat (6) @(posedge clock_in);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_reset();
    `CHK(led, 12'h000)
    rd(SPG_CTRL_OFS, q);
    `CHK(q, 32'h0000_0005)
    wr(SPG_STATUS_OFS, 32'h0000_1234);
    rd(SPG_STATUS_OFS, q);
    `CHK(q, 32'h0000_0000)
    rd(8'h40, q);
    `CHK(q, 32'h0000_0000)
  endtask
  task automatic t_spread();
    int i;
    clr <= 1'b1;
    for (i = 0; i < 12; i++)
      wr(SPG_VALUE_BASE + 8'(4 * i), {16'h0000, vals[i]});
    rd(SPG_VALUE_BASE, q);
    `CHK(q, 32'h0000_FFFF)
    clr <= 1'b0;
    wr(SPG_CTRL_OFS, 32'h0000_0004);
    i = 0;
    q = '0;
    while (q < 32'h0000_044C && i < 2000)
    begin
      rd(SPG_STATUS_OFS, q);
      i++;
    end
    if (i == 2000)
    begin
      error_cnt++;
      stop_test();
    end
    for (i = 1; i < 12; i++)
      `CHK(on_cnt[i], 16'(ticks[i] * DIV))
    `CHK(led, 12'h001)
    wr(SPG_CTRL_OFS, 32'h0000_0005);
    repeat (3) @(posedge clock_in);
    #1 `CHK(led, 12'h000)
    repeat (20) @(posedge clock_in);
    rd(SPG_STATUS_OFS, q);
    `CHK(q, 32'h0000_0000)
  endtask
  task automatic t_ext();
    wr(SPG_CTRL_OFS, 32'h0000_0007);
    pulses(3);
    rd(SPG_STATUS_OFS, q);
    `CHK(q, 32'h0000_0000)
    wr(SPG_CTRL_OFS, 32'h0000_0006);
    pulses(5);
    repeat (8) @(posedge clock_in);
    addr <= SPG_STATUS_OFS;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    #1 q = rdata;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    `CHK(q, 32'h0000_0005)
    #1 `CHK(rdata, 32'h0000_0005)
    wr(SPG_CTRL_OFS, 32'h0000_0003);
    wr(SPG_CTRL_OFS, 32'h0000_0002);
    pulses(4);
    repeat (8) @(posedge clock_in);
    rd(SPG_STATUS_OFS, q);
    `CHK(q, 32'h0000_0004)
  endtask
  task automatic t_int_fall();
    wr(SPG_CTRL_OFS, 32'h0000_0001);
    wr(SPG_CTRL_OFS, 32'h0000_0000);
    repeat (10 * DIV) @(posedge clock_in);
    rd(SPG_STATUS_OFS, q);
    `CHK(q, 32'h0000_000A)
  endtask
  initial
  begin
    forever #10 clock_in = ~clock_in;
  end
  initial
  begin
    resetn_in = 1'b0;
    serial_clock_in = 1'b0;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    clr = 1'b1;
    addr = '0;
    wdata = '0;
    repeat (4) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_reset();
    t_spread();
    t_ext();
    t_int_fall();
    stop_test();
  end
endmodule
